// file: rtl/ser_pkg.sv
// Package of register selects, field positions and reset values for status event reporting
package ser_pkg;
  // ----------------------------------------------------------------
  // Register selects for the command port
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_STD_EVENT   = 4'h0;  // Standard event register (read clears)
  localparam logic [3:0] SEL_STD_ENABLE  = 4'h1;  // Standard event enable mask
  localparam logic [3:0] SEL_QUES_COND   = 4'h2;  // Questionable condition
  localparam logic [3:0] SEL_QUES_EVENT  = 4'h3;  // Questionable event (read clears)
  localparam logic [3:0] SEL_QUES_ENABLE = 4'h4;  // Questionable enable mask
  localparam logic [3:0] SEL_ALARM_COND  = 4'h5;  // Alarm condition
  localparam logic [3:0] SEL_ALARM_EVENT = 4'h6;  // Alarm event (read clears)
  localparam logic [3:0] SEL_ALARM_EN    = 4'h7;  // Alarm enable mask
  localparam logic [3:0] SEL_OPER_COND   = 4'h8;  // Operation condition
  localparam logic [3:0] SEL_OPER_EVENT  = 4'h9;  // Operation event (read clears)
  localparam logic [3:0] SEL_OPER_EN     = 4'ha;  // Operation enable mask
  localparam logic [3:0] SEL_STB         = 4'hb;  // Status byte query
  localparam logic [3:0] SEL_STB_EN      = 4'hc;  // Status byte enable mask
  localparam logic [3:0] SEL_PSC         = 4'hd;  // Power-on clear setting

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ALM_LIMIT_LSB  = 0;   // Alarm limit bits 0..3
  localparam int ALM_QUEUE_BIT  = 4;   // Alarm queue not empty
  localparam int ALM_OVFL_BIT   = 5;   // Alarm queue overflow
  localparam int OPER_SCAN_BIT  = 4;   // Scan in progress
  localparam int OPER_CFG_BIT   = 8;   // Configuration change
  localparam int OPER_MEM_BIT   = 9;   // Memory threshold
  localparam int STB_QUES_BIT   = 3;   // Questionable summary
  localparam int STB_MAV_BIT    = 4;   // Message available
  localparam int STB_STD_BIT    = 5;   // Standard event summary
  localparam int STB_MSS_BIT    = 6;   // Master summary
  localparam int STB_OPER_BIT   = 7;   // Operation summary
  localparam int STB_ALARM_BIT  = 1;   // Alarm summary

  // ----------------------------------------------------------------
  // Reset values and implemented questionable bits
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD16 = 16'h0000;  // Cleared 16-bit register
  localparam logic [7:0]  RST_BYTE   = 8'h00;     // Cleared 8-bit register
  localparam logic        RST_PSC    = 1'b1;      // Power-on clear setting default
  localparam logic [15:0] QUES_USED  = 16'h1e07;  // Implemented questionable bits
endpackage : ser_pkg

// file: rtl/ser_event_group.sv
// One register group: latched event register, enable mask and summary bit
module ser_event_group (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Event inputs and clears
  input  wire logic [15:0] set_bits,      // One-cycle event pulses
  input  wire logic        clr_event,     // Clear-status or event read
  // Mask control
  input  wire logic        mask_wr,       // Host writes mask
  input  wire logic [15:0] mask_wdata,    // New mask value
  input  wire logic        mask_clr,      // Preset or power-on clear
  // State
  output logic      [15:0] event_ff,      // Latched events
  output logic      [15:0] enable_ff,     // Enable mask
  output logic             summary_ff     // Masked summary
);
  // ----------------------------------------------------------------
  // Event latch
  // ----------------------------------------------------------------
  // Set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_ff <= ser_pkg::RST_WORD16;
    end else if (clr_event) begin
      event_ff <= set_bits;
    end else begin
      event_ff <= event_ff | set_bits;
    end
  end

  // ----------------------------------------------------------------
  // Enable mask
  // ----------------------------------------------------------------
  // Writing 0 clears the mask through the ordinary write path
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enable_ff <= ser_pkg::RST_WORD16;
    end else if (mask_wr) begin
      enable_ff <= mask_wdata;
    end else if (mask_clr) begin
      enable_ff <= ser_pkg::RST_WORD16;
    end
  end

  // ----------------------------------------------------------------
  // Summary bit, one cycle behind the registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      summary_ff <= 1'b0;
    end else begin
      summary_ff <= |(event_ff & enable_ff);
    end
  end
endmodule : ser_event_group

// file: rtl/ser_edge.sv
// Rising-edge detector for condition levels that latch into event registers
module ser_edge (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Levels in, rising edges out
  input  wire logic [15:0] level,
  output logic      [15:0] rise
);
  logic [15:0] prev_ff;  // Level one cycle ago

  // Remember the previous level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_ff <= ser_pkg::RST_WORD16;
    end else begin
      prev_ff <= level;
    end
  end

  assign rise = level & ~prev_ff;
endmodule : ser_edge

// file: rtl/ser_status_top.sv
// Status event reporting: standard, questionable, alarm, operation groups and status byte
//
// Behaviour
// - Clear-status or event query clears standard events
// - Zero write clears std mask; every power-on clears it
// - Alarm limits one to four set bits 0-3
// - Bit 4 shows alarm queue not empty
// - Alarm condition implements only bit 4
// - Queue overflow discard sets alarm bit 5
// - Clear-status or read clears alarm events
// - Alarm mask cleared: power-on, preset, zero write
// - Operation bit 4 follows scan running
// - Front-panel config change sets bit 8; scan clears
// - Memory threshold reached sets operation bit 9
// - Clear-status or read clears operation events
// - Operation mask cleared: power-on, preset, zero write
// - Status byte query keeps master summary bit
// - Status byte mask changes only by write or power-on
// - Questionable condition read-only; factory reset clears
// - Questionable events stay until read or clear
// - Preset clears questionable mask; readback shows mask
// - Standard events stay until clear-status or query
// - Std mask survives preset and clear-status
// - Standard event summary goes to status byte bit 5
module ser_status_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,           // Power-on reset
  // Host command port
  input  wire logic        cmd_wr,        // Register write strobe
  input  wire logic        cmd_rd,        // Register read/query strobe
  input  wire logic [3:0]  cmd_sel,       // Register select
  input  wire logic [15:0] cmd_wdata,     // Write value
  input  wire logic        cmd_cls,       // Clear-status command
  input  wire logic        cmd_preset,    // Status preset command
  input  wire logic        cmd_factory,   // Factory reset command
  input  wire logic        serial_poll,   // Serial poll strobe
  output logic      [15:0] cmd_rdata_ff,  // Read value
  output logic             cmd_rvalid_ff, // Read value valid pulse
  // Event sources
  input  wire logic [7:0]  std_set,       // Standard event pulses
  input  wire logic [15:0] ques_cond_set, // Questionable condition set pulses
  input  wire logic [3:0]  alarm_hit,     // Alarm on limits 1..4
  input  wire logic        alarm_q_nonempty, // Alarm queue holds entries
  input  wire logic        alarm_q_ovfl,  // Alarm data discarded
  input  wire logic        scan_running,  // Scan in progress level
  input  wire logic        scan_start,    // New scan initiated
  input  wire logic        cfg_change,    // Front-panel config altered
  input  wire logic        mem_thresh,    // Readings reached threshold level
  input  wire logic        msg_avail,     // Output queue holds a message
  // Status outputs
  output logic      [7:0]  status_byte_ff, // Status byte with master summary
  output logic             srq_ff         // Service request level
);
  // ----------------------------------------------------------------
  // Decode of host accesses
  // ----------------------------------------------------------------
  // Returns one when the access hits the given select
  function automatic logic hit(input logic strobe, input logic [3:0] sel,
                               input logic [3:0] want);
    hit = strobe && (sel == want);
  endfunction : hit

  logic        psc_ff;          // Power-on clear setting
  logic        por_ff;          // High for the first cycle after reset
  logic        std_clr_ff;      // Pending power-on mask clear for standard group
  logic [15:0] ques_cond_ff;    // Questionable condition
  logic [15:0] oper_cond_ff;    // Operation condition
  logic [7:0]  stb_en_ff;       // Status byte enable mask
  logic        mss_ff;          // Master summary latched for poll
  logic [15:0] alarm_cond;      // Alarm condition view
  logic [15:0] std_ev, std_en, ques_ev, ques_en, alm_ev, alm_en, op_ev, op_en;
  logic        std_sum, ques_sum, alm_sum, op_sum;
  logic [15:0] ques_rise, alm_rise, op_rise;
  logic [15:0] alarm_set;       // Alarm event pulses
  logic [7:0]  stb_now;         // Status byte before master summary
  logic        rqs;             // Request for service

  // ----------------------------------------------------------------
  // Power-on marker and power-on clear setting
  // ----------------------------------------------------------------
  // Reset reloads the setting to one, so in the cycle after reset the clear always fires
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      por_ff <= 1'b1;
    end else begin
      por_ff <= 1'b0;
    end
  end

  // Setting written by host; each reset reloads the reset value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      psc_ff <= ser_pkg::RST_PSC;
    end else if (hit(cmd_wr, cmd_sel, ser_pkg::SEL_PSC)) begin
      psc_ff <= cmd_wdata[0];
    end
  end

  // Standard mask clear at power-on only when the setting is one
  assign std_clr_ff = por_ff && psc_ff;

  // ----------------------------------------------------------------
  // Condition registers
  // ----------------------------------------------------------------
  // Questionable condition: sticky until factory reset, never read-cleared
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ques_cond_ff <= ser_pkg::RST_WORD16;
    end else if (cmd_factory) begin
      ques_cond_ff <= ser_pkg::RST_WORD16;
    end else begin
      ques_cond_ff <= (ques_cond_ff | ques_cond_set) & ser_pkg::QUES_USED;
    end
  end

  // Configuration change is set by the front panel and cleared by a new scan
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oper_cond_ff <= ser_pkg::RST_WORD16;
    end else begin
      oper_cond_ff <= ser_pkg::RST_WORD16;
      oper_cond_ff[ser_pkg::OPER_SCAN_BIT] <= scan_running;
      oper_cond_ff[ser_pkg::OPER_MEM_BIT]  <= mem_thresh;
      if (cfg_change) begin
        oper_cond_ff[ser_pkg::OPER_CFG_BIT] <= 1'b1;
      end else if (scan_start) begin
        oper_cond_ff[ser_pkg::OPER_CFG_BIT] <= 1'b0;
      end else begin
        oper_cond_ff[ser_pkg::OPER_CFG_BIT] <= oper_cond_ff[ser_pkg::OPER_CFG_BIT];
      end
    end
  end

  // Alarm condition implements only the queue occupancy bit
  always_comb begin
    alarm_cond = ser_pkg::RST_WORD16;
    alarm_cond[ser_pkg::ALM_QUEUE_BIT] = alarm_q_nonempty;
  end

  // ----------------------------------------------------------------
  // Edge detection feeding event registers
  // ----------------------------------------------------------------
  // Threshold re-arms only after the count drops and rises again
  ser_edge u_ques_edge (
    .clk_sys (clk_sys),
    .rst     (rst),
    .level   (ques_cond_ff),
    .rise    (ques_rise)
  );
  ser_edge u_alm_edge (
    .clk_sys (clk_sys),
    .rst     (rst),
    .level   (alarm_cond),
    .rise    (alm_rise)
  );
  ser_edge u_op_edge (
    .clk_sys (clk_sys),
    .rst     (rst),
    .level   (oper_cond_ff),
    .rise    (op_rise)
  );

  // Alarm limit and overflow events are pulses straight from their sources
  always_comb begin
    alarm_set = alm_rise;
    alarm_set[ser_pkg::ALM_LIMIT_LSB +: 4] = alarm_hit;
    alarm_set[ser_pkg::ALM_OVFL_BIT] = alarm_q_ovfl;
  end

  // ----------------------------------------------------------------
  // Register groups
  // ----------------------------------------------------------------
  // Standard events: cleared by clear-status or query; mask kept on preset
  ser_event_group u_std (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .set_bits   ({8'h00, std_set}),
    .clr_event  (cmd_cls || hit(cmd_rd, cmd_sel, ser_pkg::SEL_STD_EVENT)),
    .mask_wr    (hit(cmd_wr, cmd_sel, ser_pkg::SEL_STD_ENABLE)),
    .mask_wdata ({8'h00, cmd_wdata[7:0]}),
    .mask_clr   (std_clr_ff),
    .event_ff   (std_ev),
    .enable_ff  (std_en),
    .summary_ff (std_sum)
  );

  // Questionable events: sticky until read or clear-status
  ser_event_group u_ques (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .set_bits   (ques_rise),
    .clr_event  (cmd_cls || hit(cmd_rd, cmd_sel, ser_pkg::SEL_QUES_EVENT)),
    .mask_wr    (hit(cmd_wr, cmd_sel, ser_pkg::SEL_QUES_ENABLE)),
    .mask_wdata (cmd_wdata),
    .mask_clr   (cmd_preset),
    .event_ff   (ques_ev),
    .enable_ff  (ques_en),
    .summary_ff (ques_sum)
  );

  // Alarm group: mask cleared at every power-on by reset, and on preset
  ser_event_group u_alarm (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .set_bits   (alarm_set),
    .clr_event  (cmd_cls || hit(cmd_rd, cmd_sel, ser_pkg::SEL_ALARM_EVENT)),
    .mask_wr    (hit(cmd_wr, cmd_sel, ser_pkg::SEL_ALARM_EN)),
    .mask_wdata (cmd_wdata),
    .mask_clr   (cmd_preset),
    .event_ff   (alm_ev),
    .enable_ff  (alm_en),
    .summary_ff (alm_sum)
  );

  // Operation group: same clearing scheme as the alarm group
  ser_event_group u_oper (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .set_bits   (op_rise),
    .clr_event  (cmd_cls || hit(cmd_rd, cmd_sel, ser_pkg::SEL_OPER_EVENT)),
    .mask_wr    (hit(cmd_wr, cmd_sel, ser_pkg::SEL_OPER_EN)),
    .mask_wdata (cmd_wdata),
    .mask_clr   (cmd_preset),
    .event_ff   (op_ev),
    .enable_ff  (op_en),
    .summary_ff (op_sum)
  );

  // ----------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------
  // Summaries are the OR of event AND mask for each group
  always_comb begin
    stb_now = ser_pkg::RST_BYTE;
    stb_now[ser_pkg::STB_ALARM_BIT] = alm_sum;
    stb_now[ser_pkg::STB_QUES_BIT]  = ques_sum;
    stb_now[ser_pkg::STB_MAV_BIT]   = msg_avail;
    stb_now[ser_pkg::STB_STD_BIT]   = std_sum;
    stb_now[ser_pkg::STB_OPER_BIT]  = op_sum;
  end

  // Request for service ignores the master summary position itself
  assign rqs = |(stb_now & stb_en_ff & ~(8'h01 << ser_pkg::STB_MSS_BIT));

  // Status byte mask: untouched by clear-status and preset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stb_en_ff <= ser_pkg::RST_BYTE;
    end else if (hit(cmd_wr, cmd_sel, ser_pkg::SEL_STB_EN)) begin
      stb_en_ff <= cmd_wdata[7:0];
    end
  end

  // Master summary latches a request; only a serial poll clears it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mss_ff <= 1'b0;
    end else if (rqs) begin
      mss_ff <= 1'b1;
    end else if (serial_poll) begin
      mss_ff <= 1'b0;
    end
  end

  // Registered status byte and service request outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_byte_ff <= ser_pkg::RST_BYTE;
      srq_ff         <= 1'b0;
    end else begin
      status_byte_ff <= stb_now | ({7'h00, mss_ff} << ser_pkg::STB_MSS_BIT);
      srq_ff         <= mss_ff;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Answer appears one cycle after the read strobe; clears act on the same edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd_rdata_ff  <= ser_pkg::RST_WORD16;
      cmd_rvalid_ff <= 1'b0;
    end else begin
      cmd_rvalid_ff <= cmd_rd;
      if (cmd_rd) begin
        case (cmd_sel)
          ser_pkg::SEL_STD_EVENT:   cmd_rdata_ff <= std_ev;
          ser_pkg::SEL_STD_ENABLE:  cmd_rdata_ff <= std_en;
          ser_pkg::SEL_QUES_COND:   cmd_rdata_ff <= ques_cond_ff;
          ser_pkg::SEL_QUES_EVENT:  cmd_rdata_ff <= ques_ev;
          ser_pkg::SEL_QUES_ENABLE: cmd_rdata_ff <= ques_en;
          ser_pkg::SEL_ALARM_COND:  cmd_rdata_ff <= alarm_cond;
          ser_pkg::SEL_ALARM_EVENT: cmd_rdata_ff <= alm_ev;
          ser_pkg::SEL_ALARM_EN:    cmd_rdata_ff <= alm_en;
          ser_pkg::SEL_OPER_COND:   cmd_rdata_ff <= oper_cond_ff;
          ser_pkg::SEL_OPER_EVENT:  cmd_rdata_ff <= op_ev;
          ser_pkg::SEL_OPER_EN:     cmd_rdata_ff <= op_en;
          // Query shows the same byte as a poll without clearing the summary
          ser_pkg::SEL_STB:         cmd_rdata_ff <= {8'h00, status_byte_ff};
          ser_pkg::SEL_STB_EN:      cmd_rdata_ff <= {8'h00, stb_en_ff};
          ser_pkg::SEL_PSC:         cmd_rdata_ff <= {15'h0000, psc_ff};
          default:                  cmd_rdata_ff <= ser_pkg::RST_WORD16;
        endcase
      end
    end
  end
endmodule : ser_status_top

// file: verification/ser_status_props.sv
// Checker of port relations for the status event reporting block
module ser_status_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Command port
  input wire logic        cmd_rd,
  input wire logic [3:0]  cmd_sel,
  input wire logic        serial_poll,
  input wire logic [15:0] cmd_rdata_ff,
  input wire logic        cmd_rvalid_ff,
  // Sources and status
  input wire logic [3:0]  alarm_hit,
  input wire logic        scan_running,
  input wire logic [7:0]  status_byte_ff,
  input wire logic        srq_ff
);
  // ----------------------------------------------------------------
  // One domain, reset masks every check
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Two alarm event reads one idle cycle apart, no alarm in between
  sequence s_alarm_rd2;
    cmd_rd && cmd_sel == ser_pkg::SEL_ALARM_EVENT && alarm_hit == 4'h0
      ##1 alarm_hit == 4'h0 ##1 cmd_rd && cmd_sel == ser_pkg::SEL_ALARM_EVENT;
  endsequence

  a_read_answers: assert property (cmd_rd |=> cmd_rvalid_ff)
    else $error("read not answered next cycle");
  a_valid_has_cause: assert property (cmd_rvalid_ff |-> $past(cmd_rd))
    else $error("read valid without a read");
  a_rdata_holds: assert property (!cmd_rd |=> $stable(cmd_rdata_ff))
    else $error("read data moved without a read");
  a_alarm_cond_bits: assert property (cmd_rd && cmd_sel == ser_pkg::SEL_ALARM_COND
    |=> (cmd_rdata_ff & 16'hffef) == 16'h0000) else $error("alarm condition extra bits");
  a_oper_cond_bits: assert property (cmd_rd && cmd_sel == ser_pkg::SEL_OPER_COND
    |=> (cmd_rdata_ff & 16'hfcef) == 16'h0000) else $error("operation condition extra bits");
  a_scan_shows: assert property (scan_running [*3] ##0
    (cmd_rd && cmd_sel == ser_pkg::SEL_OPER_COND) |=> cmd_rdata_ff[4])
    else $error("scan bit missing");
  a_alarm_rd_clears: assert property (s_alarm_rd2 |=> cmd_rdata_ff[3:0] == 4'h0)
    else $error("alarm event not cleared by read");
  a_query_keeps_mss: assert property (cmd_rd && cmd_sel == ser_pkg::SEL_STB
    && !serial_poll && status_byte_ff[6] |=> status_byte_ff[6])
    else $error("status query cleared master summary");
  a_srq_is_mss: assert property (srq_ff == status_byte_ff[6])
    else $error("service request differs from master summary");
  a_unmapped_zero: assert property (cmd_rd && cmd_sel > 4'hd |=> cmd_rdata_ff == 16'h0000)
    else $error("unmapped read not zero");

  // Main scenarios reached
  c_alarm_rd2: cover property (s_alarm_rd2);
  c_srq_up: cover property ($rose(srq_ff));
  c_poll: cover property (serial_poll ##1 !status_byte_ff[6]);
endmodule : ser_status_props

bind ser_status_top ser_status_props i_props (.clk_sys, .rst, .cmd_rd, .cmd_sel,
  .serial_poll, .cmd_rdata_ff, .cmd_rvalid_ff, .alarm_hit, .scan_running, .status_byte_ff,
  .srq_ff);

// file: verification/ser_host_model.sv
// Remote host model that issues register accesses and status commands
module ser_host_model (
  // Clock
  input  wire logic        clk_sys,
  // Command port towards the device
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic [3:0]       cmd_sel,
  output logic [15:0]      cmd_wdata,
  output logic             cmd_cls,
  output logic             cmd_preset,
  output logic             cmd_factory,
  output logic             serial_poll,
  input  wire logic [15:0] cmd_rdata_ff
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet port from time zero
  initial begin
    {cmd_wr, cmd_rd, cmd_cls, cmd_preset, cmd_factory, serial_poll} = 6'h00;
    cmd_sel   = 4'h0;
    cmd_wdata = 16'h0000;
  end

  // Write a mask as the weighted sum of wanted bits; one cycle strobe
  task automatic wr(input logic [3:0] sel, input logic [15:0] val);
    @(negedge clk_sys);
    cmd_sel   = sel;
    cmd_wdata = val;
    cmd_wr    = 1'b1;
    @(negedge clk_sys);
    cmd_wr    = 1'b0;
  endtask : wr

  // Read: answer is registered, so it is settled by the next falling edge
  task automatic rd(input logic [3:0] sel, output logic [15:0] val);
    @(negedge clk_sys);
    cmd_sel = sel;
    cmd_rd  = 1'b1;
    @(negedge clk_sys);
    cmd_rd  = 1'b0;
    val     = cmd_rdata_ff;
  endtask : rd

  // Command pulse: {clear-status, preset, factory reset, serial poll}
  task automatic ctl(input logic [3:0] m);
    @(negedge clk_sys);
    {cmd_cls, cmd_preset, cmd_factory, serial_poll} = m;
    @(negedge clk_sys);
    {cmd_cls, cmd_preset, cmd_factory, serial_poll} = 4'h0;
  endtask : ctl
endmodule : ser_host_model

// file: verification/tb.sv
// Self-checking testbench for the status event reporting block
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_sys, rst, cmd_wr, cmd_rd, cmd_cls, cmd_preset, cmd_factory, serial_poll;
  logic [3:0]  cmd_sel, alarm_hit;
  logic [15:0] cmd_wdata, cmd_rdata_ff, ques_cond_set, r;
  logic        cmd_rvalid_ff, alarm_q_nonempty, alarm_q_ovfl, scan_running, scan_start;
  logic        cfg_change, mem_thresh, msg_avail, srq_ff;
  logic [7:0]  std_set, status_byte_ff;
  int          n_mismatch = 0;
  int          n_checks = 0;

  // Clock at 100 MHz
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ser_status_top i_dut (.clk_sys, .rst, .cmd_wr, .cmd_rd, .cmd_sel, .cmd_wdata, .cmd_cls,
    .cmd_preset, .cmd_factory, .serial_poll, .cmd_rdata_ff, .cmd_rvalid_ff, .std_set,
    .ques_cond_set, .alarm_hit, .alarm_q_nonempty, .alarm_q_ovfl, .scan_running, .scan_start,
    .cfg_change, .mem_thresh, .msg_avail, .status_byte_ff, .srq_ff);
  ser_host_model i_host (.clk_sys, .cmd_wr, .cmd_rd, .cmd_sel, .cmd_wdata, .cmd_cls,
    .cmd_preset, .cmd_factory, .serial_poll, .cmd_rdata_ff);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  // Register read compared with an expected word
  task automatic chk(input logic [3:0] sel, input logic [15:0] exp);
    i_host.rd(sel, r);
    n_checks++;
    if (r !== exp) begin
      n_mismatch++;
      $display("unexpected read at %0t: sel %h got %h exp %h", $time, sel, r, exp);
    end
  endtask : chk

  // Status byte compared after the summary pipeline has settled
  task automatic chk_stb(input logic [7:0] exp);
    cyc(6);
    n_checks++;
    if (status_byte_ff !== exp || srq_ff !== exp[6]) begin
      n_mismatch++;
      $display("unexpected status at %0t: got %h exp %h", $time, status_byte_ff, exp);
    end
  endtask : chk_stb

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  // Hang guard
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {std_set, ques_cond_set, alarm_hit} = 28'h0;
    {alarm_q_nonempty, alarm_q_ovfl, scan_running, scan_start} = 4'h0;
    {cfg_change, mem_thresh, msg_avail} = 3'h0;
    cyc(16);
    rst = 1'b0;
    // Each alarm limit and the overflow, queue goes non-empty
    for (int i = 0; i < 4; i++) begin
      alarm_hit = 4'h1 << i;
      cyc(1);
    end
    {alarm_hit, alarm_q_ovfl, alarm_q_nonempty} = 6'h03;
    cyc(1);
    alarm_q_ovfl = 1'b0;
    cyc(4);
    chk(ser_pkg::SEL_ALARM_EVENT, 16'h003f);
    chk(ser_pkg::SEL_ALARM_EVENT, 16'h0000);
    chk(ser_pkg::SEL_ALARM_COND, 16'h0010);
    chk(4'he, 16'h0000);
    $display("test alarm done");
    // Alarm summary into the status byte and the master summary
    i_host.wr(ser_pkg::SEL_ALARM_EN, 16'h0001);
    i_host.wr(ser_pkg::SEL_STB_EN, 16'h0002);
    alarm_hit = 4'h1;
    cyc(1);
    alarm_hit = 4'h0;
    chk_stb(8'h42);
    chk(ser_pkg::SEL_STB, 16'h0042);
    chk_stb(8'h42);
    chk(ser_pkg::SEL_ALARM_EVENT, 16'h0001);
    i_host.ctl(4'h1);
    chk_stb(8'h00);
    $display("test summary done");
    // Standard group: routing, clear-status, preset and zero writes
    std_set = 8'h01;
    cyc(1);
    std_set = 8'h00;
    i_host.wr(ser_pkg::SEL_STD_ENABLE, 16'h0001);
    i_host.wr(ser_pkg::SEL_STB_EN, 16'h0020);
    i_host.wr(ser_pkg::SEL_ALARM_EN, 16'h00ff);
    i_host.wr(ser_pkg::SEL_OPER_EN, 16'h0310);
    msg_avail = 1'b1;
    chk_stb(8'h70);
    msg_avail = 1'b0;
    i_host.ctl(4'h8);
    i_host.ctl(4'h1);
    chk_stb(8'h00);
    chk(ser_pkg::SEL_STD_EVENT, 16'h0000);
    i_host.ctl(4'h4);
    chk(ser_pkg::SEL_STD_ENABLE, 16'h0001);
    chk(ser_pkg::SEL_STB_EN, 16'h0020);
    chk(ser_pkg::SEL_ALARM_EN, 16'h0000);
    chk(ser_pkg::SEL_OPER_EN, 16'h0000);
    i_host.wr(ser_pkg::SEL_STD_ENABLE, 16'h0000);
    chk(ser_pkg::SEL_STD_ENABLE, 16'h0000);
    $display("test standard done");
    // Operation group: scan, configuration change, memory threshold
    {scan_running, cfg_change, mem_thresh} = 3'h7;
    cyc(1);
    cfg_change = 1'b0;
    cyc(4);
    chk(ser_pkg::SEL_OPER_COND, 16'h0310);
    chk(ser_pkg::SEL_OPER_EVENT, 16'h0310);
    chk(ser_pkg::SEL_OPER_EVENT, 16'h0000);
    scan_start = 1'b1;
    cyc(1);
    scan_start = 1'b0;
    cyc(3);
    chk(ser_pkg::SEL_OPER_COND, 16'h0210);
    {scan_running, mem_thresh} = 2'h0;
    $display("test operation done");
    // Questionable group: sticky condition, event, mask
    ques_cond_set = 16'h0001;
    cyc(1);
    ques_cond_set = 16'h0000;
    cyc(4);
    chk(ser_pkg::SEL_QUES_COND, 16'h0001);
    chk(ser_pkg::SEL_QUES_COND, 16'h0001);
    chk(ser_pkg::SEL_QUES_EVENT, 16'h0001);
    chk(ser_pkg::SEL_QUES_EVENT, 16'h0000);
    i_host.wr(ser_pkg::SEL_QUES_ENABLE, 16'h0007);
    chk(ser_pkg::SEL_QUES_ENABLE, 16'h0007);
    i_host.ctl(4'h4);
    chk(ser_pkg::SEL_QUES_ENABLE, 16'h0000);
    i_host.ctl(4'h2);
    cyc(2);
    chk(ser_pkg::SEL_QUES_COND, 16'h0000);
    $display("test questionable done");
    // Power-on in mid-run clears the masks again
    i_host.wr(ser_pkg::SEL_ALARM_EN, 16'h0003);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk(ser_pkg::SEL_ALARM_EN, 16'h0000);
    chk(ser_pkg::SEL_OPER_EN, 16'h0000);
    chk(ser_pkg::SEL_STD_ENABLE, 16'h0000);
    chk(ser_pkg::SEL_PSC, 16'h0001);
    $display("test power-on done");
    summarize();
  end
endmodule : tb
